//--- design/fan_ctrl_pkg.sv
/*
 Constants, register map and types shared by the fan lock, restart and commutation logic.
 Assumes a single 40 MHz clock; analog levels are carried as codes in 10 mV units.
*/
package fan_ctrl_pkg;
	// Clock and derived time bases
	localparam int CLOCK_HZ = 40_000_000;
	localparam int CYCLES_PER_US = CLOCK_HZ / 1_000_000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1_000;

	// Lock timer periods and thresholds
	localparam int RESTART_ON_MS = 560;
	localparam int WAIT_OFF_MS = 6800;
	localparam int TIMER_UPPER_THRESHOLD_MV = 3000;
	localparam int TIMER_LOWER_THRESHOLD_MV = 1000;
	localparam logic [31:0] RESTART_ON_CYCLES = 32'(RESTART_ON_MS * CYCLES_PER_MS);
	localparam logic [31:0] WAIT_OFF_CYCLES = 32'(WAIT_OFF_MS * CYCLES_PER_MS);
	// Stall interval spans zero to the upper threshold, on period spans the two thresholds
	localparam logic [31:0] STALL_DETECT_CYCLES = 32'((RESTART_ON_MS * CYCLES_PER_MS)
		/ (TIMER_UPPER_THRESHOLD_MV - TIMER_LOWER_THRESHOLD_MV) * TIMER_UPPER_THRESHOLD_MV);

	// Commutation delay
	localparam int COMMUTATION_DELAY_US = 100;
	localparam logic [7:0] COMMUTATION_DELAY_RESET = 8'(COMMUTATION_DELAY_US);

	// PWM generator
	localparam int PWM_FREQ_HZ = 24_000;
	localparam int PWM_STEPS = 200;
	localparam int PWM_STEP_CYCLES = CLOCK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
	localparam logic [7:0] DUTY_FULL = 8'(PWM_STEPS);

	// Speed demand levels, 10 mV units: 300 is 0 % drive, 100 is 100 % drive
	localparam logic [9:0] SPEED_ZERO_LEVEL = 10'h12c;
	localparam logic [9:0] SPEED_FULL_LEVEL = 10'h064;
	localparam logic [8:0] SPEED_DEMAND_RESET = 9'h064;
	localparam logic [8:0] MINIMUM_SPEED_RESET = 9'h12c;

	// Register byte offsets
	localparam logic [7:0] SPEED_DEMAND_ADDR = 8'h00;
	localparam logic [7:0] MINIMUM_SPEED_ADDR = 8'h04;
	localparam logic [7:0] COMMUTATION_DELAY_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0c;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;

	// Status register fields
	localparam int STATUS_LOCKED_BIT = 0;
	localparam int STATUS_DRIVE_BIT = 1;
	localparam int STATUS_PHASE_BIT = 2;
	localparam int STATUS_HALL_BIT = 3;
	localparam int STATUS_LIMIT_BIT = 4;
	localparam int STATUS_DUTY_LSB = 8;

	// Interrupt status and mask fields
	localparam int IRQ_WIDTH = 3;
	localparam int IRQ_LOCK_BIT = 0;
	localparam int IRQ_RESTART_BIT = 1;
	localparam int IRQ_LIMIT_BIT = 2;

	// Lock timer states, Gray coded along run, wait, restart, wait
	typedef enum logic [1:0] {
		LOCK_RUN = 2'b00,
		LOCK_WAIT = 2'b01,
		LOCK_RESTART = 2'b11
	} lock_state_type;
endpackage

//--- design/lock_if.sv
/*
 Link between the commutation top and its lock and restart timer.
 Assumes both ends run on the same clock; the edge strobe is a one-cycle pulse.
*/
`timescale 1ns/10ps
interface lock_if;
	logic hall_edge; // Filtered Hall transition pulse
	logic locked; // Locked-rotor condition
	logic drive_enable; // Phase drive allowed
	logic restart_active; // In a restart attempt

	modport ctrl (output hall_edge, input locked, input drive_enable, input restart_active);
	modport timer (input hall_edge, output locked, output drive_enable, output restart_active);
endinterface

//--- design/lock_restart_timer.sv
/*
 Stall detection and endless wait / restart cycle of the locked-rotor timer.
 Assumes the Hall edge strobe arrives already synchronised and filtered.
*/
`timescale 1ns/10ps
module lock_restart_timer
	import fan_ctrl_pkg::*;
#(
	parameter logic [31:0] STALL_CYCLES = STALL_DETECT_CYCLES,
	parameter logic [31:0] WAIT_CYCLES = WAIT_OFF_CYCLES,
	parameter logic [31:0] RESTART_CYCLES = RESTART_ON_CYCLES
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	lock_if.timer bus // Edge in, lock state out
);
	lock_state_type state_q;
	logic [31:0] cnt_q;

	// State and period counter; every Hall edge while running clears the stall count
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= LOCK_RUN;
			cnt_q <= 32'h0;
		end else begin
			case (state_q)
				LOCK_RUN: begin
					if (bus.hall_edge) begin
						cnt_q <= 32'h0;
					end else if (cnt_q >= STALL_CYCLES - 32'h1) begin
						state_q <= LOCK_WAIT;
						cnt_q <= 32'h0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				LOCK_WAIT: begin
					// Edges here come from a coasting rotor and are ignored
					if (cnt_q >= WAIT_CYCLES - 32'h1) begin
						state_q <= LOCK_RESTART;
						cnt_q <= 32'h0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				LOCK_RESTART: begin
					if (bus.hall_edge) begin
						state_q <= LOCK_RUN;
						cnt_q <= 32'h0;
					end else if (cnt_q >= RESTART_CYCLES - 32'h1) begin
						state_q <= LOCK_WAIT;
						cnt_q <= 32'h0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				default: begin
					state_q <= LOCK_RUN;
					cnt_q <= 32'h0;
				end
			endcase
		end
	end

	// Decoded lock outputs
	assign bus.locked = (state_q != LOCK_RUN);
	assign bus.drive_enable = (state_q != LOCK_WAIT);
	assign bus.restart_active = (state_q == LOCK_RESTART);

	// Checks on the lock sequence
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_stall_to_wait: assert property (state_q == LOCK_RUN && !bus.hall_edge && cnt_q == STALL_CYCLES - 32'h1
		|=> state_q == LOCK_WAIT && cnt_q == 32'h0) else $error("stall did not enter wait");
	a_wait_to_restart: assert property (state_q == LOCK_WAIT && cnt_q == WAIT_CYCLES - 32'h1
		|=> state_q == LOCK_RESTART) else $error("wait did not end in restart");
	a_restart_to_wait: assert property (state_q == LOCK_RESTART && !bus.hall_edge
		&& cnt_q == RESTART_CYCLES - 32'h1 |=> state_q == LOCK_WAIT) else $error("restart did not return to wait");
	a_edge_clears_stall: assert property (state_q == LOCK_RUN && bus.hall_edge
		|=> state_q == LOCK_RUN && cnt_q == 32'h0) else $error("edge did not clear stall count");
	a_restart_success: assert property (state_q == LOCK_RESTART && bus.hall_edge
		|=> !bus.locked) else $error("edge in restart did not resume running");
	c_lock_cycle: cover property (state_q == LOCK_WAIT ##1 state_q == LOCK_RESTART);
endmodule // lock_restart_timer

//--- design/fan_lock_restart_commutation.sv
/*
 Single-phase fan pre-driver control: Hall commutation with delay, PWM with current limit and
 minimum speed, locked-rotor detection with auto restart, open-drain flags, APB registers.
 Assumes comparator outputs (Hall, over-current) arrive asynchronously on pins and an APB master
 on the same 40 MHz clock.

// Operation
// - A rotor that stops turning is flagged locked after the stall interval and all phases go off.
// - While locked, wait periods with drive off alternate with restart periods with drive on, forever.
// - The restart drive period is 0.56 s and the wait period 6.8 s, a ratio of about 1:12.
// - The timer runs between 1 V and 3 V so the stall interval is 1.5 restart periods.
// - The locked flag reads high when stopped and low when running, only ever driven low.
// - The speed pulse is an open-drain copy of the Hall state.
// - Each low-side output carries both commutation and PWM chopping.
// - Each high-side output carries commutation only, no chopping.
// - The low-side output of the inactive phase stays low.
// - Winding current above the limit reduces the PWM drive ratio.
// - Current below the limit leaves the speed demand unchanged.
// - The minimum speed duty always wins over the current limit reduction.
// - Phase b is active while the positive Hall input is above the negative one, else phase a.
// - Demand maps linearly 3 V to 1 V onto 0 % to 100 % duty, and above 3 V drive is off.
// - A phase change follows a Hall transition after a 100 us delay that software can adjust.
*/
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module fan_lock_restart_commutation
	import fan_ctrl_pkg::*;
#(
	parameter logic [31:0] STALL_CYCLES = STALL_DETECT_CYCLES, // Stall-detect interval
	parameter logic [31:0] WAIT_CYCLES = WAIT_OFF_CYCLES, // Locked wait period
	parameter logic [31:0] RESTART_CYCLES = RESTART_ON_CYCLES // Restart drive period
) (
	input wire logic clock, // 40 MHz clock
	input wire logic rst, // Asynchronous reset
	input wire logic hall_pos_above_neg, // Hall comparator pin
	input wire logic sense_above_limit, // Sense above current_limit_level
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic phase_a_high_side, // Phase a high-side drive
	output logic phase_b_high_side, // Phase b high-side drive
	output logic phase_a_low_side, // Phase a low-side drive
	output logic phase_b_low_side, // Phase b low-side drive
	output logic speed_pulse_out_o, // Speed pulse level, always low
	output logic speed_pulse_out_oe, // Speed pulse pull-down enable
	output logic locked_flag_o, // Locked flag level, always low
	output logic locked_flag_oe, // Locked flag pull-down enable
	output logic irq // Interrupt, level high
);
	lock_if lock_bus ();

	logic [1:0] sync1_q, sync2_q, sync3_q, filt_q;
	logic hall_prev_q, over_prev_q, locked_prev_q;
	logic hall_edge;
	logic [8:0] speed_demand_in_q, minimum_speed_level_q;
	logic [7:0] commutation_delay_adj_q;
	logic [IRQ_WIDTH-1:0] irq_status_q, irq_mask_q, irq_set;
	logic [3:0] step_cnt_q;
	logic [7:0] pwm_cnt_q, duty_q, duty_d, min_duty;
	logic period_end, pwm_on, speed_disable;
	logic [8:0] limit_corr_q;
	logic [9:0] limited_level;
	logic phase_sel_q;
	logic [15:0] delay_cnt_q, delay_target;
	logic commutate_now;
	logic apb_write, apb_setup;
	logic [31:0] rd_word;
	logic speed_pulse_oe_q, locked_flag_oe_q;
	logic phase_a_hi_q, phase_b_hi_q, phase_a_lo_q, phase_b_lo_q;

	// Level code to duty, 0 at or above the zero level, full at or below the full level
	function automatic logic [7:0] duty_from_level(input logic [9:0] level);
		if (level >= SPEED_ZERO_LEVEL) begin
			return 8'h00;
		end else if (level <= SPEED_FULL_LEVEL) begin
			return DUTY_FULL;
		end else begin
			return 8'(SPEED_ZERO_LEVEL - level);
		end
	endfunction

	// Three-stage sampling of pin comparators; a bit changes when stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
			filt_q <= 2'h0;
		end else begin
			sync1_q <= {sense_above_limit, hall_pos_above_neg};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < 2; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					filt_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// Edge history for Hall, over-current and lock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hall_prev_q <= 1'b0;
			over_prev_q <= 1'b0;
			locked_prev_q <= 1'b0;
		end else begin
			hall_prev_q <= filt_q[0];
			over_prev_q <= filt_q[1];
			locked_prev_q <= lock_bus.locked;
		end
	end

	assign hall_edge = filt_q[0] ^ hall_prev_q;
	assign lock_bus.hall_edge = hall_edge;

	lock_restart_timer #(
		.STALL_CYCLES(STALL_CYCLES),
		.WAIT_CYCLES(WAIT_CYCLES),
		.RESTART_CYCLES(RESTART_CYCLES)
	) u_lock_timer (
		.clock(clock),
		.rst(rst),
		.bus(lock_bus)
	);

	// Commutation delay: count cycles while the selected phase lags the Hall state
	assign delay_target = 16'(commutation_delay_adj_q) * 16'(CYCLES_PER_US);
	assign commutate_now = (phase_sel_q != filt_q[0]) && (delay_cnt_q + 16'h1 >= delay_target);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_sel_q <= 1'b0;
			delay_cnt_q <= 16'h0;
		end else if (phase_sel_q == filt_q[0]) begin
			delay_cnt_q <= 16'h0;
		end else if (commutate_now) begin
			phase_sel_q <= filt_q[0];
			delay_cnt_q <= 16'h0;
		end else begin
			delay_cnt_q <= delay_cnt_q + 16'h1;
		end
	end

	// PWM time base; duty is taken once a period so a pulse is never cut short
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_cnt_q <= 4'h0;
			pwm_cnt_q <= 8'h00;
		end else if (step_cnt_q == 4'(PWM_STEP_CYCLES - 1)) begin
			step_cnt_q <= 4'h0;
			pwm_cnt_q <= (pwm_cnt_q == 8'(PWM_STEPS - 1)) ? 8'h00 : pwm_cnt_q + 8'h01;
		end else begin
			step_cnt_q <= step_cnt_q + 4'h1;
		end
	end

	assign period_end = (step_cnt_q == 4'(PWM_STEP_CYCLES - 1)) && (pwm_cnt_q == 8'(PWM_STEPS - 1));

	// Current limit correction; cleared at once when current is back under the limit,
	// which trades some chatter at the limit for an untouched demand below it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			limit_corr_q <= 9'h000;
		end else if (!filt_q[1]) begin
			limit_corr_q <= 9'h000;
		end else if (period_end && limit_corr_q < 9'(DUTY_FULL)) begin
			limit_corr_q <= limit_corr_q + 9'h001;
		end
	end

	// Effective duty: correction raises the demand level, minimum speed sets a floor
	assign speed_disable = ({1'b0, speed_demand_in_q} > SPEED_ZERO_LEVEL);
	assign limited_level = {1'b0, speed_demand_in_q} + {1'b0, limit_corr_q};
	assign min_duty = duty_from_level({1'b0, minimum_speed_level_q});

	always_comb begin
		if (speed_disable) begin
			duty_d = 8'h00;
		end else if (duty_from_level(limited_level) < min_duty) begin
			duty_d = min_duty;
		end else begin
			duty_d = duty_from_level(limited_level);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			duty_q <= 8'h00;
		end else if (period_end) begin
			duty_q <= duty_d;
		end
	end

	assign pwm_on = (pwm_cnt_q < duty_q);

	// Bridge and flag outputs, registered so the pins never glitch
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_a_hi_q <= 1'b0;
			phase_b_hi_q <= 1'b0;
			phase_a_lo_q <= 1'b0;
			phase_b_lo_q <= 1'b0;
			speed_pulse_oe_q <= 1'b0;
			locked_flag_oe_q <= 1'b0;
		end else begin
			phase_a_hi_q <= lock_bus.drive_enable && !phase_sel_q;
			phase_b_hi_q <= lock_bus.drive_enable && phase_sel_q;
			phase_a_lo_q <= lock_bus.drive_enable && !phase_sel_q && pwm_on;
			phase_b_lo_q <= lock_bus.drive_enable && phase_sel_q && pwm_on;
			speed_pulse_oe_q <= !filt_q[0];
			locked_flag_oe_q <= !lock_bus.locked;
		end
	end

	assign phase_a_high_side = phase_a_hi_q;
	assign phase_b_high_side = phase_b_hi_q;
	assign phase_a_low_side = phase_a_lo_q;
	assign phase_b_low_side = phase_b_lo_q;
	assign speed_pulse_out_o = 1'b0;
	assign speed_pulse_out_oe = speed_pulse_oe_q;
	assign locked_flag_o = 1'b0;
	assign locked_flag_oe = locked_flag_oe_q;

	// APB decode; zero wait states, unmapped offsets answer with an error
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr inside {SPEED_DEMAND_ADDR, MINIMUM_SPEED_ADDR,
		COMMUTATION_DELAY_ADDR, STATUS_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR});

	// Software settings
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			speed_demand_in_q <= SPEED_DEMAND_RESET;
			minimum_speed_level_q <= MINIMUM_SPEED_RESET;
			commutation_delay_adj_q <= COMMUTATION_DELAY_RESET;
			irq_mask_q <= '0;
		end else if (apb_write) begin
			case (paddr)
				SPEED_DEMAND_ADDR: speed_demand_in_q <= pwdata[8:0];
				MINIMUM_SPEED_ADDR: minimum_speed_level_q <= pwdata[8:0];
				COMMUTATION_DELAY_ADDR: commutation_delay_adj_q <= pwdata[7:0];
				IRQ_MASK_ADDR: irq_mask_q <= pwdata[IRQ_WIDTH-1:0];
				default: begin
				end
			endcase
		end
	end

	// Sticky events; a set in the clearing cycle survives the write of one
	assign irq_set[IRQ_LOCK_BIT] = lock_bus.locked && !locked_prev_q;
	assign irq_set[IRQ_RESTART_BIT] = !lock_bus.locked && locked_prev_q;
	assign irq_set[IRQ_LIMIT_BIT] = filt_q[1] && !over_prev_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_status_q <= '0;
		end else if (apb_write && paddr == IRQ_STATUS_ADDR) begin
			irq_status_q <= (irq_status_q & ~pwdata[IRQ_WIDTH-1:0]) | irq_set;
		end else begin
			irq_status_q <= irq_status_q | irq_set;
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// Read data is captured in the setup cycle and stands through the access cycle
	always_comb begin
		rd_word = 32'h0;
		case (paddr)
			SPEED_DEMAND_ADDR: rd_word[8:0] = speed_demand_in_q;
			MINIMUM_SPEED_ADDR: rd_word[8:0] = minimum_speed_level_q;
			COMMUTATION_DELAY_ADDR: rd_word[7:0] = commutation_delay_adj_q;
			STATUS_ADDR: begin
				rd_word[STATUS_LOCKED_BIT] = lock_bus.locked;
				rd_word[STATUS_DRIVE_BIT] = lock_bus.restart_active;
				rd_word[STATUS_PHASE_BIT] = phase_sel_q;
				rd_word[STATUS_HALL_BIT] = filt_q[0];
				rd_word[STATUS_LIMIT_BIT] = filt_q[1];
				rd_word[STATUS_DUTY_LSB +: 8] = duty_q;
			end
			IRQ_STATUS_ADDR: rd_word[IRQ_WIDTH-1:0] = irq_status_q;
			IRQ_MASK_ADDR: rd_word[IRQ_WIDTH-1:0] = irq_mask_q;
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (apb_setup && !pwrite) begin
			prdata <= rd_word;
		end
	end

	// Checks on outputs and their causes
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_lock_drive_off: assert property (!lock_bus.drive_enable ##1 !lock_bus.drive_enable
		|-> !phase_a_high_side && !phase_b_high_side && !phase_a_low_side && !phase_b_low_side)
		else $error("phase output active during locked wait");
	a_flag_follows_lock: assert property ($rose(lock_bus.locked) |=> !locked_flag_oe)
		else $error("locked flag not released on lock");
	a_speed_pulse_copy: assert property ($changed(filt_q[0]) |=> speed_pulse_out_oe == !$past(filt_q[0]))
		else $error("speed pulse does not follow hall");
	a_low_needs_high: assert property ((phase_a_low_side |-> phase_a_high_side) and
		(phase_b_low_side |-> phase_b_high_side)) else $error("low side on without its commutation");
	// Outputs lag their causes by one cycle, so the first cycle out of reset is left out
	a_high_no_chop: assert property (!$past(rst) && $stable(lock_bus.drive_enable) && $stable(phase_sel_q)
		|=> $stable(phase_a_high_side) && $stable(phase_b_high_side)) else $error("high side chopped");
	a_inactive_low: assert property (phase_a_low_side |-> !phase_b_low_side && !phase_b_high_side)
		else $error("both phases driven");
	a_limit_raises: assert property (filt_q[1] && period_end && limit_corr_q < 9'(DUTY_FULL)
		|=> limit_corr_q == $past(limit_corr_q) + 9'h001) else $error("limit did not back off");
	a_limit_idle: assert property (!filt_q[1] |=> limit_corr_q == 9'h000)
		else $error("limit active below threshold");
	a_min_priority: assert property (!speed_disable |-> duty_d >= min_duty)
		else $error("duty below minimum speed");
	a_disable_off: assert property (speed_disable && period_end |=> duty_q == 8'h00 ##1 !pwm_on)
		else $error("disable did not stop pwm");
	a_delay_hold: assert property (phase_sel_q != filt_q[0] && !commutate_now
		|=> phase_sel_q == $past(phase_sel_q)) else $error("phase changed before delay");
	a_delay_switch: assert property (commutate_now |=> phase_sel_q == $past(filt_q[0]))
		else $error("phase not changed after delay");
	// Flag pulled low again on resume, and a restart attempt really drives the bridge
	a_flag_on_resume: assert property ($fell(lock_bus.locked) |=> locked_flag_oe)
		else $error("locked flag not pulled low on resume");
	a_restart_drives: assert property (lock_bus.restart_active |=> phase_a_high_side || phase_b_high_side)
		else $error("no commutation during restart");
	c_lock_entered: cover property ($rose(lock_bus.locked));
	c_restart_ok: cover property ($fell(lock_bus.locked));
	c_limit_active: cover property (filt_q[1] && period_end);
	c_commutate: cover property (commutate_now);
endmodule // fan_lock_restart_commutation

//--- verification/fan_far_side.sv
/*
 Far side of the fan controller: Hall sensor, sense comparator and flag pull-ups.
 Assumes the bench commands rotor position and winding overload.
*/
`timescale 1ns/10ps
module fan_far_side (
	input wire logic magnet_north, // Commanded rotor pole
	input wire logic overload, // Commanded overcurrent
	input wire logic speed_pulse_out_o, // Speed pin level
	input wire logic speed_pulse_out_oe, // Speed pin pull-down
	input wire logic locked_flag_o, // Lock pin level
	input wire logic locked_flag_oe, // Lock pin pull-down
	output logic hall_pos_above_neg, // Hall comparator
	output logic sense_above_limit, // Sense comparator
	output logic speed_pin_level, // Speed pin as seen
	output logic lock_pin_level // Lock pin as seen
);
	// Sensors follow the commanded rotor state
	assign hall_pos_above_neg = magnet_north;
	assign sense_above_limit = overload;
	// Released pins float up through the pull-ups
	assign speed_pin_level = speed_pulse_out_oe ? speed_pulse_out_o : 1'b1;
	assign lock_pin_level = locked_flag_oe ? locked_flag_o : 1'b1;
endmodule // fan_far_side

//--- verification/testbench.sv
/*
 Self-checking bench: PWM, commutation, current limit and lock restart.
 Assumes a shortened stall, wait and restart time and the far-side model.
*/
`timescale 1ns/10ps
module testbench;
	import fan_ctrl_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, magnet_north = 1'b0, overload = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, err, hall_pos_above_neg, sense_above_limit, speed_pin_level, lock_pin_level;
	logic phase_a_high_side, phase_b_high_side, phase_a_low_side, phase_b_low_side;
	logic speed_pulse_out_o, speed_pulse_out_oe, locked_flag_o, locked_flag_oe;
	int fails = 0;
	int n_checks = 0;
	// Stall kept long so the other scenarios never lock
	fan_lock_restart_commutation #(.STALL_CYCLES(32'd30000), .WAIT_CYCLES(32'd1200),
		.RESTART_CYCLES(32'd200)) u_dut (.clock, .rst, .hall_pos_above_neg, .sense_above_limit,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_a_high_side,
		.phase_b_high_side, .phase_a_low_side, .phase_b_low_side, .speed_pulse_out_o,
		.speed_pulse_out_oe, .locked_flag_o, .locked_flag_oe, .irq);
	fan_far_side u_far (.magnet_north, .overload, .speed_pulse_out_o, .speed_pulse_out_oe,
		.locked_flag_o, .locked_flag_oe, .hall_pos_above_neg, .sense_above_limit, .speed_pin_level,
		.lock_pin_level);
	// Clock
	always #12.5 clock = ~clock;
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic duty(input logic [7:0] e);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rd[15:8], e);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Reset values and an unmapped place
	task automatic t_regs;
		apb(1'b0, SPEED_DEMAND_ADDR, 32'h0);
		chk(rd, 32'h064);
		apb(1'b0, MINIMUM_SPEED_ADDR, 32'h0);
		chk(rd, 32'h12c);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		chk(pready, 1'b1);
		$display("t_regs done");
	endtask
	// Disable, full drive, half drive with chopping on the active low side only
	task automatic t_pwm;
		int na = 0, nb = 0, nh = 0;
		apb(1'b1, SPEED_DEMAND_ADDR, 32'h12d);
		repeat (3300) @(posedge clock);
		duty(8'h00);
		chk({phase_a_low_side, phase_a_high_side}, 2'b01);
		apb(1'b1, SPEED_DEMAND_ADDR, 32'h064);
		repeat (3300) @(posedge clock);
		duty(8'hc8);
		apb(1'b1, SPEED_DEMAND_ADDR, 32'h0c8);
		repeat (3300) @(posedge clock);
		duty(8'h64);
		repeat (1600) begin
			@(posedge clock);
			na += int'(phase_a_low_side === 1'b1);
			nb += int'(phase_b_low_side === 1'b1);
			nh += int'(phase_a_high_side === 1'b1);
		end
		chk(na, 800);
		chk(nb, 0);
		chk(nh, 1600);
		$display("t_pwm done");
	endtask
	// Hall edge, speed pulse and delayed phase change
	task automatic t_hall;
		apb(1'b1, COMMUTATION_DELAY_ADDR, 32'h1);
		chk(speed_pin_level, 1'b0);
		magnet_north <= 1'b1;
		repeat (10) @(posedge clock);
		chk({speed_pin_level, phase_b_high_side}, 2'b10);
		repeat (50) @(posedge clock);
		chk({phase_a_high_side, phase_b_high_side, phase_a_low_side}, 3'b010);
		$display("t_hall done");
	endtask
	// Overcurrent backs off to the floor, then releases
	task automatic t_limit;
		apb(1'b1, MINIMUM_SPEED_ADDR, 32'h0cd);
		overload <= 1'b1;
		repeat (4900) @(posedge clock);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rd[15:8] < 8'h64 && rd[15:8] > 8'h5f, 1'b1);
		repeat (16000) @(posedge clock);
		duty(8'h5f);
		apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
		chk({rd[IRQ_LIMIT_BIT], irq}, 2'b10);
		overload <= 1'b0;
		repeat (3300) @(posedge clock);
		duty(8'h64);
		$display("t_limit done");
	endtask
	// Stall, wait, restart, wait, restart, resume
	task automatic t_lock;
		int n;
		apb(1'b1, IRQ_STATUS_ADDR, 32'h7);
		apb(1'b1, IRQ_MASK_ADDR, 32'h3);
		magnet_north <= 1'b0;
		for (n = 0; n < 31000 && lock_pin_level !== 1'b1; n++) @(posedge clock);
		chk(n > 29990 && n < 30012, 1'b1);
		chk({irq, phase_a_high_side, phase_b_high_side, phase_a_low_side, phase_b_low_side}, 5'h10);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rd[1:0], 2'b01);
		for (n = 0; n < 1300 && phase_a_high_side !== 1'b1; n++) @(posedge clock);
		chk(n > 1190 && n < 1210, 1'b1);
		for (n = 0; n < 300 && phase_a_high_side === 1'b1; n++) @(posedge clock);
		chk({n > 195 && n < 205, lock_pin_level}, 2'b11);
		for (n = 0; n < 1300 && phase_a_high_side !== 1'b1; n++) @(posedge clock);
		magnet_north <= 1'b1;
		repeat (10) @(posedge clock);
		chk(lock_pin_level, 1'b0);
		apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
		chk(rd[2:0], 3'b011);
		apb(1'b1, IRQ_STATUS_ADDR, 32'h3);
		repeat (2) @(posedge clock);
		chk(irq, 1'b0);
		$display("t_lock done");
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_pwm();
		t_hall();
		t_limit();
		t_lock();
		close_out();
	end
	// Watchdog, well past the expected 68500 cycles
	initial begin
		repeat (100000) @(posedge clock);
		fails++;
		$display("ERROR at %0t timeout %h %h", $time, 1'b1, 1'b0);
		close_out();
	end
endmodule // testbench
